// file: rtl/tct_top.sv
`timescale 1ns/10ps
// Functional notes
// RULE1 - Second overflow flag set on overflow, cleared on vector
// RULE2 - First overflow flag set on overflow, cleared on vector
// RULE3 - First two timers count only while run bit set; in split mode the second timer runs without it
// RULE4 - External flag set by pin, edge flag cleared on service
// RULE5 - Type bit: zero low level, one falling edge
// RULE6 - Gating bit makes timer also wait for pin high
// RULE7 - Source select: divided clock or count pin falls
// RULE8 - Second timer modes: 13-bit, 16-bit, reload, halt
// RULE9 - First timer mode three splits into two bytes
// RULE10 - Reload mode refills low byte from high byte
// RULE11 - First timer count bytes reset to zero
// RULE12 - Third timer is cascaded 16-bit count
// RULE13 - Third timer source select, counts while run set
// RULE14 - Up/down enable: direction pin picks direction
// RULE15 - Up overflow past top sets flag, loads reload
// RULE16 - Down at reload value sets flag, loads top
// RULE17 - External flag toggles per wrap, no interrupt; code toggles it only while the up/down enable bit is set
// RULE18 - Timer source advances once per six clocks
// RULE19 - Count pin sampled per cycle, high then low counts
// RULE20 - Setting run bit keeps existing count
// RULE21 - Split high byte uses second run and flag
// RULE22 - Software stops timer before preset or mode change
module tct_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_irq_a_pin,
  input  wire logic        ext_irq_b_pin,
  input  wire logic        first_count_pin,
  input  wire logic        second_count_pin,
  input  wire logic        third_count_pin,
  input  wire logic        third_direction_pin,
  input  wire logic        first_ovf_vector,
  input  wire logic        second_ovf_vector,
  input  wire logic        ext_a_vector,
  input  wire logic        ext_b_vector,
  output logic             first_ovf_irq,
  output logic             second_ovf_irq,
  output logic             ext_a_irq,
  output logic             ext_b_irq,
  output logic             third_irq
);
  import tct_pkg::*;

  function automatic logic [11:0] addr_of(input logic [7:0] idx);
    addr_of = {2'b00, idx, 2'b00};
  endfunction : addr_of

  // Returns {overflow, high, low} after one count step
  function automatic logic [16:0] step(input tct_mode_t m, input logic en,
                                       input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] nl;
    logic [7:0] nh;
    logic       ov;
    nl = lo;
    nh = hi;
    ov = 1'b0;
    if (en) begin
      case (m)
        TCT_MODE_13BIT: begin
          nl[4:0] = lo[4:0] + 5'h01;
          if (&lo[4:0]) begin
            nh = hi + 8'h01;
            ov = &hi;
          end
        end
        TCT_MODE_16BIT: begin
          {nh, nl} = {hi, lo} + 16'h0001;
          ov = &{hi, lo};
        end
        TCT_MODE_RELOAD: begin
          nl = (&lo) ? hi : lo + 8'h01;
          ov = &lo;
        end
        default: begin
          nl = lo + 8'h01;
          ov = &lo;
        end
      endcase
    end
    step = {ov, nh, nl};
  endfunction : step

  //////////////////////////////////////////////////////////////////////////
  logic [7:0]  run_flags_q;
  logic [7:0]  mode_sel_q;
  logic [7:0]  first_low_q;
  logic [7:0]  first_high_q;
  logic [7:0]  second_low_q;
  logic [7:0]  second_high_q;
  logic [7:0]  third_ctrl_q;
  logic        updown_en_q;
  logic [15:0] cnt2_q;
  logic [15:0] rl2_q;
  logic [2:0]  pre_q;
  logic        tick_q;
  logic        s0_q;
  logic        s1_q;
  logic        s2_q;
  logic        ea_q;
  logic        eb_q;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;

  tct_mode_t   mode0;
  tct_mode_t   mode1;
  logic        acc;
  logic        wr;
  logic [7:0]  wd;
  logic        split;
  logic        src0;
  logic        src1;
  logic        src2;
  logic        en0;
  logic        en1;
  logic        en0h;
  logic        en2;
  logic        down2;
  logic [16:0] r0;
  logic [16:0] r1;
  logic [7:0]  first_high_d;
  logic        ovf0h;
  logic [15:0] cnt2_d;
  logic        wrap2;
  logic [7:0]  run_flags_d;
  logic [7:0]  third_ctrl_d;

  assign mode0 = tct_mode_t'(mode_sel_q[FIRST_MODE_POS +: 2]);
  assign mode1 = tct_mode_t'(mode_sel_q[SECOND_MODE_POS +: 2]);
  assign split = (mode0 == TCT_MODE_SPLIT);
  assign acc   = psel & penable & pready_q;
  assign wr    = acc & pwrite;
  assign wd    = pwdata[7:0];

  //////////////////////////////////////////////////////////////////////////
  // Peripheral cycle strobe and pin samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q  <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      pre_q  <= (pre_q == PRESCALE_LAST) ? 3'h0 : pre_q + 3'h1;  // see RULE18
      tick_q <= (pre_q == PRESCALE_LAST);
    end
  end

  // Samples move only on the strobe, so an edge needs two cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s0_q <= 1'b0;
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else if (tick_q) begin
      s0_q <= first_count_pin;  // see RULE19
      s1_q <= second_count_pin;
      s2_q <= third_count_pin;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ea_q <= 1'b1;
      eb_q <= 1'b1;
    end else begin
      ea_q <= ext_irq_a_pin;
      eb_q <= ext_irq_b_pin;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Count enables
  assign src0 = mode_sel_q[FIRST_SRC_POS] ? (tick_q & s0_q & ~first_count_pin)
              : tick_q;  // see RULE7
  assign src1 = mode_sel_q[SECOND_SRC_POS] ? (tick_q & s1_q & ~second_count_pin) : tick_q;
  assign src2 = third_ctrl_q[THIRD_SRC_POS] ? (tick_q & s2_q & ~third_count_pin)
              : tick_q;  // see RULE13
  assign en0  = run_flags_q[FIRST_RUN_POS] & (~mode_sel_q[FIRST_GATE_POS] | ext_irq_a_pin)
              & src0;  // see RULE3, RULE6
  // Split mode takes the second run bit, so the second timer runs free
  assign en1  = (split | run_flags_q[SECOND_RUN_POS])
              & (~mode_sel_q[SECOND_GATE_POS] | ext_irq_b_pin)
              & (mode1 != TCT_MODE_SPLIT) & src1;  // see RULE8, RULE3, RULE6
  assign en0h = split & run_flags_q[SECOND_RUN_POS] & tick_q;  // see RULE9, RULE21
  assign en2  = third_ctrl_q[THIRD_RUN_POS] & src2;  // see RULE13
  assign down2 = updown_en_q & ~third_direction_pin;  // see RULE14

  assign r0 = step(mode0, en0, first_low_q, first_high_q);  // see RULE10
  assign r1 = step(mode1, en1, second_low_q, second_high_q);  // see RULE8, RULE10

  always_comb begin
    first_high_d = r0[15:8];
    ovf0h = 1'b0;
    if (split) begin
      first_high_d = en0h ? first_high_q + 8'h01 : first_high_q;
      ovf0h = en0h & (&first_high_q);
    end
  end

  always_comb begin
    cnt2_d = cnt2_q;
    wrap2  = 1'b0;
    if (en2) begin
      if (down2) begin
        wrap2  = (cnt2_q == rl2_q);
        cnt2_d = wrap2 ? THIRD_TOP : cnt2_q - 16'h0001;  // see RULE16
      end else begin
        wrap2  = (cnt2_q == THIRD_TOP);
        cnt2_d = wrap2 ? rl2_q : cnt2_q + 16'h0001;  // see RULE12, RULE15
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Count registers; a bus write beats the count step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_low_q  <= REG_RESET;  // see RULE11
      first_high_q <= REG_RESET;
    end else begin
      first_low_q  <= (wr && paddr == addr_of(FIRST_LOW_IDX))  ? wd : r0[7:0];
      first_high_q <= (wr && paddr == addr_of(FIRST_HIGH_IDX)) ? wd : first_high_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_low_q  <= REG_RESET;
      second_high_q <= REG_RESET;
    end else begin
      second_low_q  <= (wr && paddr == addr_of(SECOND_LOW_IDX))  ? wd : r1[7:0];
      second_high_q <= (wr && paddr == addr_of(SECOND_HIGH_IDX)) ? wd : r1[15:8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt2_q <= {REG_RESET, REG_RESET};
      rl2_q  <= {REG_RESET, REG_RESET};
      updown_en_q <= 1'b0;
    end else begin
      cnt2_q <= cnt2_d;
      if (wr && paddr == addr_of(THIRD_CNT_L_IDX)) cnt2_q[7:0]  <= wd;
      if (wr && paddr == addr_of(THIRD_CNT_H_IDX)) cnt2_q[15:8] <= wd;
      if (wr && paddr == addr_of(THIRD_RLD_L_IDX)) rl2_q[7:0]   <= wd;
      if (wr && paddr == addr_of(THIRD_RLD_H_IDX)) rl2_q[15:8]  <= wd;
      if (wr && paddr == addr_of(THIRD_MODE_IDX))  updown_en_q  <= wd[UPDOWN_EN_POS];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Flags: write, then vector clear, then hardware set wins
  always_comb begin
    run_flags_d = (wr && paddr == addr_of(RUN_FLAGS_IDX)) ? wd : run_flags_q;  // see RULE20
    if (second_ovf_vector) run_flags_d[SECOND_OVF_POS] = 1'b0;
    if (first_ovf_vector)  run_flags_d[FIRST_OVF_POS]  = 1'b0;
    if (ext_a_vector && run_flags_q[EXT_A_TYPE_POS]) run_flags_d[EXT_A_FLAG_POS] = 1'b0;  // see RULE4
    if (ext_b_vector && run_flags_q[EXT_B_TYPE_POS]) run_flags_d[EXT_B_FLAG_POS] = 1'b0;
    if (split ? ovf0h : r1[16]) run_flags_d[SECOND_OVF_POS] = 1'b1;  // see RULE1, RULE21
    if (r0[16]) run_flags_d[FIRST_OVF_POS] = 1'b1;  // see RULE2
    // Level mode tracks the pin; edge mode catches a fall
    if (run_flags_q[EXT_A_TYPE_POS]) begin
      if (ea_q && !ext_irq_a_pin) run_flags_d[EXT_A_FLAG_POS] = 1'b1;  // see RULE5
    end else begin
      run_flags_d[EXT_A_FLAG_POS] = ~ext_irq_a_pin;
    end
    if (run_flags_q[EXT_B_TYPE_POS]) begin
      if (eb_q && !ext_irq_b_pin) run_flags_d[EXT_B_FLAG_POS] = 1'b1;  // see RULE5
    end else begin
      run_flags_d[EXT_B_FLAG_POS] = ~ext_irq_b_pin;
    end
  end

  always_comb begin
    third_ctrl_d = (wr && paddr == addr_of(THIRD_CTRL_IDX)) ? wd : third_ctrl_q;
    third_ctrl_d[5:3] = 3'h0;
    third_ctrl_d[0]   = 1'b0;
    if (wrap2) third_ctrl_d[THIRD_OVF_POS] = 1'b1;  // see RULE15, RULE16
    if (wrap2 && updown_en_q) begin
      third_ctrl_d[THIRD_EXT_POS] = ~third_ctrl_d[THIRD_EXT_POS];  // see RULE17
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_flags_q  <= REG_RESET;
      third_ctrl_q <= REG_RESET;
      mode_sel_q   <= REG_RESET;
    end else begin
      run_flags_q  <= run_flags_d;
      third_ctrl_q <= third_ctrl_d;
      if (wr && paddr == addr_of(MODE_SEL_IDX)) mode_sel_q <= wd;
    end
  end

  // Interrupt requests are the flag flops; external toggle flag raises none
  assign first_ovf_irq  = run_flags_q[FIRST_OVF_POS];
  assign second_ovf_irq = run_flags_q[SECOND_OVF_POS];
  assign ext_a_irq      = run_flags_q[EXT_A_FLAG_POS];
  assign ext_b_irq      = run_flags_q[EXT_B_FLAG_POS];
  assign third_irq      = third_ctrl_q[THIRD_OVF_POS];

  //////////////////////////////////////////////////////////////////////////
  // APB: one wait state, data and error registered
  logic [7:0] rd_byte;
  logic       hit;

  always_comb begin
    hit = 1'b1;
    case (paddr)
      addr_of(RUN_FLAGS_IDX):   rd_byte = run_flags_q;
      addr_of(MODE_SEL_IDX):    rd_byte = mode_sel_q;
      addr_of(FIRST_LOW_IDX):   rd_byte = first_low_q;
      addr_of(SECOND_LOW_IDX):  rd_byte = second_low_q;
      addr_of(FIRST_HIGH_IDX):  rd_byte = first_high_q;
      addr_of(SECOND_HIGH_IDX): rd_byte = second_high_q;
      addr_of(THIRD_CTRL_IDX):  rd_byte = third_ctrl_q;
      addr_of(THIRD_MODE_IDX):  rd_byte = {7'h00, updown_en_q};
      addr_of(THIRD_RLD_L_IDX): rd_byte = rl2_q[7:0];
      addr_of(THIRD_RLD_H_IDX): rd_byte = rl2_q[15:8];
      addr_of(THIRD_CNT_L_IDX): rd_byte = cnt2_q[7:0];
      addr_of(THIRD_CNT_H_IDX): rd_byte = cnt2_q[15:8];
      default: begin
        rd_byte = 8'h00;
        hit     = 1'b0;
      end
    endcase
  end

  // Unmapped writes are dropped and flagged with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~hit;
      if (psel && penable && !pready_q) prdata_q <= {24'h000000, rd_byte};
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  //////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_tick_period: assert property (tick_q |=> !tick_q [*5] ##1 tick_q)  // see RULE18
    else $error("peripheral strobe not every six clocks");

  a_run_stop: assert property (!run_flags_q[FIRST_RUN_POS] && !split && !wr  // see RULE3
                               |=> $stable(first_low_q) && $stable(first_high_q))
    else $error("first timer moved while stopped");

  a_gate_hold: assert property (mode_sel_q[FIRST_GATE_POS] && !ext_irq_a_pin && !wr  // see RULE6
                                |=> $stable(first_low_q))
    else $error("gated first timer moved with pin low");

  a_first_ovf: assert property (en0 && mode0 == TCT_MODE_16BIT && first_low_q == 8'hff  // see RULE2
                                && first_high_q == 8'hff |=> first_ovf_irq)
    else $error("first overflow flag not set");

  a_split_ovf: assert property (en0h && first_high_q == 8'hff |=> second_ovf_irq)  // see RULE21
    else $error("split high byte overflow lost");

  a_low_reload: assert property (en0 && mode0 == TCT_MODE_RELOAD && !wr  // see RULE10
                                 && first_low_q == 8'hff |=> first_low_q == $past(first_high_q))
    else $error("low byte not reloaded");

  a_third_up: assert property (en2 && !down2 && cnt2_q == 16'hffff && !wr  // see RULE15
                               |=> cnt2_q == $past(rl2_q) && third_irq)
    else $error("third timer up wrap wrong");

  a_third_down: assert property (en2 && down2 && cnt2_q == rl2_q && !wr  // see RULE16
                                 |=> cnt2_q == 16'hffff && third_irq
                                 && third_ctrl_q[THIRD_EXT_POS] != $past(third_ctrl_q[THIRD_EXT_POS]))
    else $error("third timer down wrap wrong");

  a_edge_flag: assert property (run_flags_q[EXT_A_TYPE_POS] && ea_q && !ext_irq_a_pin  // see RULE4
                                |=> ext_a_irq)
    else $error("falling edge not caught");

  a_apb_answer: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");

endmodule : tct_top

// file: rtl/tct_pkg.sv
package tct_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] RUN_FLAGS_IDX   = 8'h88;
  localparam logic [7:0] MODE_SEL_IDX    = 8'h89;
  localparam logic [7:0] FIRST_LOW_IDX   = 8'h8a;
  localparam logic [7:0] SECOND_LOW_IDX  = 8'h8b;
  localparam logic [7:0] FIRST_HIGH_IDX  = 8'h8c;
  localparam logic [7:0] SECOND_HIGH_IDX = 8'h8d;
  localparam logic [7:0] THIRD_CTRL_IDX  = 8'hc8;
  localparam logic [7:0] THIRD_MODE_IDX  = 8'hc9;
  localparam logic [7:0] THIRD_RLD_L_IDX = 8'hca;
  localparam logic [7:0] THIRD_RLD_H_IDX = 8'hcb;
  localparam logic [7:0] THIRD_CNT_L_IDX = 8'hcc;
  localparam logic [7:0] THIRD_CNT_H_IDX = 8'hcd;

  // timer_run_and_flags fields
  localparam int SECOND_OVF_POS  = 7;
  localparam int SECOND_RUN_POS  = 6;
  localparam int FIRST_OVF_POS   = 5;
  localparam int FIRST_RUN_POS   = 4;
  localparam int EXT_B_FLAG_POS  = 3;
  localparam int EXT_B_TYPE_POS  = 2;
  localparam int EXT_A_FLAG_POS  = 1;
  localparam int EXT_A_TYPE_POS  = 0;

  // timer_mode_select fields
  localparam int SECOND_GATE_POS = 7;
  localparam int SECOND_SRC_POS  = 6;
  localparam int SECOND_MODE_POS = 4;
  localparam int FIRST_GATE_POS  = 3;
  localparam int FIRST_SRC_POS   = 2;
  localparam int FIRST_MODE_POS  = 0;

  // third_control_reg and third_mode_reg fields
  localparam int THIRD_OVF_POS   = 7;
  localparam int THIRD_EXT_POS   = 6;
  localparam int THIRD_RUN_POS   = 2;
  localparam int THIRD_SRC_POS   = 1;
  localparam int UPDOWN_EN_POS   = 0;

  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam logic [15:0] THIRD_TOP   = 16'hffff;

  // Peripheral cycle in clock periods
  localparam int         PER_CYCLE_CLKS = 6;
  localparam logic [2:0] PRESCALE_LAST  = 3'(PER_CYCLE_CLKS - 1);

  typedef enum logic [1:0] {
    TCT_MODE_13BIT  = 2'b00,
    TCT_MODE_16BIT  = 2'b01,
    TCT_MODE_RELOAD = 2'b10,
    TCT_MODE_SPLIT  = 2'b11
  } tct_mode_t;

endpackage : tct_pkg

// file: verification/tct_cpu_model.sv
`timescale 1ns/10ps
module tct_cpu_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] irq,
  input  wire logic [3:0] ack_en,
  output logic      [3:0] vec
);
  logic [3:0] vec_q;
  // Vector only when the bench allows it; the gap cycle lets the flag drop first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_q <= 4'h0;
    end else begin
      vec_q <= irq & ack_en & ~vec_q;
    end
  end
  assign vec = vec_q;
endmodule : tct_cpu_model

// file: verification/timer_counter_trio_tb.sv
`timescale 1ns/10ps
module timer_counter_trio_tb;
  import tct_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        pin_a, pin_b, cnt1, cnt2, cnt3, dir3, irq3;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  irq, vec, ack_en;
  logic [7:0]  rd;
  int          n_fail, comparisons;

  tct_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_a_pin(pin_a), .ext_irq_b_pin(pin_b),
    .first_count_pin(cnt1), .second_count_pin(cnt2), .third_count_pin(cnt3),
    .third_direction_pin(dir3), .first_ovf_vector(vec[0]), .second_ovf_vector(vec[1]),
    .ext_a_vector(vec[2]), .ext_b_vector(vec[3]), .first_ovf_irq(irq[0]),
    .second_ovf_irq(irq[1]), .ext_a_irq(irq[2]), .ext_b_irq(irq[3]), .third_irq(irq3));
  tct_cpu_model cpu (.pclk(pclk), .presetn(presetn), .irq(irq), .ack_en(ack_en), .vec(vec));

  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic chk_byte(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_byte

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_bit

  // One edge of idle bus first, so psel is never assigned twice in a step
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) n_fail++;
  endtask : apb

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  task automatic wait_lvl(input int k, input logic lvl, input int max);
    int n;
    n = 0;
    while ((k == 4 ? irq3 : irq[k]) !== lvl && n < max) begin
      @(posedge pclk);
      n++;
    end
    chk_bit("irq level", lvl, k == 4 ? irq3 : irq[k]);
  endtask : wait_lvl

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    apb(0, RUN_FLAGS_IDX, 8'h00);
    chk_byte("run flags", 8'h00, rd);
    apb(0, FIRST_LOW_IDX, 8'h00);
    chk_byte("first low", 8'h00, rd);
    apb(0, FIRST_HIGH_IDX, 8'h00);
    chk_byte("first high", 8'h00, rd);
    apb(0, 8'h00, 8'h00);
    chk_bit("slverr", 1'b1, err);
    chk_byte("unmapped", 8'h00, rd);
  endtask : t_reset

  task automatic t_first_run;
    apb(1, MODE_SEL_IDX, 8'h01);
    apb(1, FIRST_LOW_IDX, 8'hfe);
    apb(1, FIRST_HIGH_IDX, 8'hff);
    idle(30);
    apb(0, FIRST_LOW_IDX, 8'h00);
    chk_byte("stopped low", 8'hfe, rd);
    apb(1, RUN_FLAGS_IDX, 8'h10);
    apb(0, FIRST_LOW_IDX, 8'h00);
    chk_bit("kept count", 1'b1, rd[7:1] == 7'h7f);
    wait_lvl(0, 1'b1, 30);
    apb(0, FIRST_HIGH_IDX, 8'h00);
    chk_byte("wrapped high", 8'h00, rd);
    ack_en <= 4'h1;
    wait_lvl(0, 1'b0, 4);
    ack_en <= 4'h0;
    apb(1, RUN_FLAGS_IDX, 8'h00);
  endtask : t_first_run

  task automatic t_reload;
    logic [7:0] held;
    apb(1, MODE_SEL_IDX, 8'h20);
    apb(1, SECOND_HIGH_IDX, 8'hf0);
    apb(1, SECOND_LOW_IDX, 8'hfe);
    apb(1, RUN_FLAGS_IDX, 8'h40);
    wait_lvl(1, 1'b1, 30);
    apb(0, SECOND_LOW_IDX, 8'h00);
    chk_bit("reload low", 1'b1, rd[7:1] == 7'h78);
    apb(0, SECOND_HIGH_IDX, 8'h00);
    chk_byte("reload high", 8'hf0, rd);
    ack_en <= 4'h2;
    wait_lvl(1, 1'b0, 4);
    ack_en <= 4'h0;
    apb(1, RUN_FLAGS_IDX, 8'h00);
    apb(1, MODE_SEL_IDX, 8'h30);
    apb(1, RUN_FLAGS_IDX, 8'h40);
    apb(0, SECOND_LOW_IDX, 8'h00);
    held = rd;
    idle(20);
    apb(0, SECOND_LOW_IDX, 8'h00);
    chk_byte("halted low", held, rd);
    apb(1, RUN_FLAGS_IDX, 8'h00);
  endtask : t_reload

  task automatic t_counter;
    apb(1, MODE_SEL_IDX, 8'h05);
    apb(1, FIRST_LOW_IDX, 8'h00);
    apb(1, FIRST_HIGH_IDX, 8'h00);
    apb(1, RUN_FLAGS_IDX, 8'h10);
    // Each level held over two strobes so it is sampled at least once
    repeat (3) begin
      cnt1 <= 1'b0;
      idle(14);
      cnt1 <= 1'b1;
      idle(14);
    end
    apb(1, RUN_FLAGS_IDX, 8'h00);
    apb(0, FIRST_LOW_IDX, 8'h00);
    chk_byte("pin count", 8'h03, rd);
  endtask : t_counter

  task automatic t_gate;
    apb(1, MODE_SEL_IDX, 8'h09);
    apb(1, FIRST_LOW_IDX, 8'h00);
    pin_a <= 1'b0;
    apb(1, RUN_FLAGS_IDX, 8'h10);
    chk_bit("level flag", 1'b1, irq[2]);
    idle(30);
    apb(0, FIRST_LOW_IDX, 8'h00);
    chk_byte("gated low", 8'h00, rd);
    pin_a <= 1'b1;
    idle(30);
    chk_bit("level release", 1'b0, irq[2]);
    apb(1, RUN_FLAGS_IDX, 8'h00);
    apb(0, FIRST_LOW_IDX, 8'h00);
    chk_bit("gate open", 1'b1, rd >= 8'h04 && rd <= 8'h07);
  endtask : t_gate

  task automatic t_edge;
    apb(1, RUN_FLAGS_IDX, 8'h04);
    chk_bit("edge idle", 1'b0, irq[3]);
    pin_b <= 1'b0;
    wait_lvl(3, 1'b1, 4);
    pin_b <= 1'b1;
    idle(5);
    chk_bit("edge held", 1'b1, irq[3]);
    ack_en <= 4'h8;
    wait_lvl(3, 1'b0, 4);
    ack_en <= 4'h0;
  endtask : t_edge

  task automatic t_split;
    apb(1, MODE_SEL_IDX, 8'h03);
    apb(1, FIRST_HIGH_IDX, 8'hfe);
    apb(1, FIRST_LOW_IDX, 8'h50);
    apb(1, RUN_FLAGS_IDX, 8'h40);
    wait_lvl(1, 1'b1, 30);
    apb(0, FIRST_LOW_IDX, 8'h00);
    chk_byte("split low", 8'h50, rd);
    apb(1, RUN_FLAGS_IDX, 8'h00);
  endtask : t_split

  task automatic t_third;
    apb(1, THIRD_RLD_L_IDX, 8'h00);
    apb(1, THIRD_RLD_H_IDX, 8'h10);
    apb(1, THIRD_CNT_L_IDX, 8'hfe);
    apb(1, THIRD_CNT_H_IDX, 8'hff);
    apb(1, THIRD_MODE_IDX, 8'h01);
    apb(1, THIRD_CTRL_IDX, 8'h04);
    wait_lvl(4, 1'b1, 30);
    apb(0, THIRD_CNT_H_IDX, 8'h00);
    chk_byte("up reload", 8'h10, rd);
    apb(0, THIRD_CTRL_IDX, 8'h00);
    chk_byte("up ctrl", 8'hc4, rd);
    apb(1, THIRD_CTRL_IDX, 8'h00);
    apb(1, THIRD_CNT_L_IDX, 8'h02);
    apb(1, THIRD_CNT_H_IDX, 8'h10);
    dir3 <= 1'b0;
    apb(1, THIRD_CTRL_IDX, 8'h04);
    wait_lvl(4, 1'b1, 30);
    apb(0, THIRD_CNT_H_IDX, 8'h00);
    chk_byte("down top", 8'hff, rd);
    apb(0, THIRD_CTRL_IDX, 8'h00);
    chk_byte("down ctrl", 8'hc4, rd);
  endtask : t_third

  // Second timer in 13-bit mode; the run write also clears the old flag
  task automatic t_prescale;
    apb(1, MODE_SEL_IDX, 8'h00);
    apb(1, SECOND_LOW_IDX, 8'hfe);
    apb(1, SECOND_HIGH_IDX, 8'hff);
    apb(1, RUN_FLAGS_IDX, 8'h40);
    idle(1);
    wait_lvl(1, 1'b1, 30);
    apb(0, SECOND_HIGH_IDX, 8'h00);
    chk_byte("prescale high", 8'h00, rd);
    apb(0, SECOND_LOW_IDX, 8'h00);
    chk_bit("prescale top bits", 1'b1, rd[7:5] == 3'h7);
    apb(1, RUN_FLAGS_IDX, 8'h00);
  endtask : t_prescale

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    n_fail = 0;
    comparisons = 0;
    {psel, penable, pwrite, presetn} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {pin_a, pin_b, cnt1, cnt2, cnt3, dir3} = 6'h3f;
    ack_en = 4'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_first_run;
    t_reload;
    t_counter;
    t_gate;
    t_edge;
    t_split;
    t_third;
    t_prescale;
    test_done;
  end

  // Whole run needs several hundred cycles; this 30000-cycle limit is far beyond it
  initial begin
    #(20 * 30000);
    n_fail++;
    test_done;
  end
endmodule : timer_counter_trio_tb
